// ==== shared/scd_pkg.sv ====
// constants shared by both ends of the supervisory call dispatcher
package scd_pkg;
  // opcode of the supervisory call
  localparam logic [7:0] OP_SUPERVISORY_CALL = 8'h00;
  // service function codes held in the accumulator
  localparam logic [7:0] FN_WARM_BOOT = 8'h00;
  localparam logic [7:0] FN_BLOCK_READ = 8'h01;
  localparam logic [7:0] FN_BLOCK_WRITE = 8'h02;
  localparam logic [7:0] FN_BLOCK_ERASE = 8'h03;
  localparam logic [7:0] FN_TABLE_READ = 8'h06;
  localparam logic [7:0] FN_BLOCK_SUM = 8'h07;
  localparam logic [7:0] FN_FIRST_CAL = 8'h08;
  localparam logic [7:0] FN_SECOND_CAL = 8'h09;
  localparam logic [7:0] FN_VERIFIED_WRITE = 8'h0A;
  localparam logic [7:0] FN_HARDWARE_BOOT = 8'h0F;
  // parameter block in page 0
  localparam logic [7:0] ADDR_FIRST_GUARD = 8'hF8;
  localparam logic [7:0] ADDR_SECOND_GUARD = 8'hF9;
  localparam logic [7:0] ADDR_BLOCK_NUMBER = 8'hFA;
  localparam logic [7:0] ADDR_BUFFER_OFFSET = 8'hFB;
  localparam logic [7:0] ADDR_CLOCK_PARAM = 8'hFC;
  localparam logic [7:0] ADDR_DELAY_PARAM = 8'hFE;
  localparam logic [1:0] PARAM_WORDS_READ = 2'h3;
  localparam logic [7:0] FIRST_GUARD_VALUE = 8'h3A;
  localparam logic [7:0] SECOND_GUARD_OFFSET = 8'h03;
  // return codes
  localparam logic [7:0] RC_SUCCESS = 8'h00;
  localparam logic [7:0] RC_PROTECTED = 8'h01;
  localparam logic [7:0] RC_SOFT_RESET = 8'h02;
  localparam logic [7:0] RC_FATAL_HALT = 8'h03;
  localparam logic [7:0] RC_VERIFY_ERROR = 8'h04;
  localparam logic [7:0] RC_CHECKSUM_FAIL = 8'h06;
  // flags register page-mode field, bits 7:6
  localparam logic [7:0] PAGE_MODE_FIELD_MASK = 8'hC0;
  // reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  // caller apb register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PARAM = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_FLAGS = 8'h0C;
  localparam logic [7:0] REG_GUARDS = 8'h10;
  // control register fields
  localparam int CTRL_GO_BIT = 8;
  localparam int CTRL_AUTO_GUARD_BIT = 9;
  // kind of flash access a service makes
  typedef enum logic [1:0] {
    SCD_ACC_NONE = 2'h0,
    SCD_ACC_READ = 2'h1,
    SCD_ACC_WRITE = 2'h2
  } scd_access_t;
endpackage

// ==== shared/scd_if.sv ====
// link between the processor core side and the call dispatcher
interface scd_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic op_valid; // core executes an opcode, one-cycle pulse
  logic [7:0] opcode;
  logic [7:0] acc;
  logic [7:0] sp;
  logic [7:0] flags;
  logic [7:0] rd_page; // indirect read page pointer
  logic [7:0] wr_page; // indirect write page pointer
  logic busy; // dispatcher holds off user code
  logic done; // one-cycle pulse, user code resumes
  logic halted;
  logic flags_wr;
  logic [7:0] flags_out;
  logic mem_req;
  logic mem_we;
  logic [7:0] mem_addr;
  logic [7:0] mem_wdata;
  logic mem_ack;
  logic [7:0] mem_rdata;

  modport dispatcher (
    input op_valid, opcode, acc, sp, flags, rd_page, wr_page, mem_ack, mem_rdata,
    output busy, done, halted, flags_wr, flags_out, mem_req, mem_we, mem_addr, mem_wdata
  );
  modport caller (
    output op_valid, opcode, acc, sp, flags, rd_page, wr_page, mem_ack, mem_rdata,
    input busy, done, halted, flags_wr, flags_out, mem_req, mem_we, mem_addr, mem_wdata
  );
endinterface

// ==== verilog/scd_decode.sv ====
// service code decoder for the call dispatcher
module scd_decode (
  input wire logic [7:0] code,
  output logic known,
  output logic check_guards,
  output scd_pkg::scd_access_t access
);
  // one table for legality, guard need and protection class
  always_comb begin
    known = 1'b1;
    check_guards = 1'b1;
    access = scd_pkg::SCD_ACC_NONE;
    unique case (code)
      scd_pkg::FN_WARM_BOOT: check_guards = 1'b0;
      scd_pkg::FN_BLOCK_READ: access = scd_pkg::SCD_ACC_READ;
      scd_pkg::FN_BLOCK_WRITE, scd_pkg::FN_BLOCK_ERASE,
      scd_pkg::FN_VERIFIED_WRITE: access = scd_pkg::SCD_ACC_WRITE;
      scd_pkg::FN_TABLE_READ, scd_pkg::FN_BLOCK_SUM, scd_pkg::FN_FIRST_CAL,
      scd_pkg::FN_SECOND_CAL, scd_pkg::FN_HARDWARE_BOOT: known = 1'b1;
      default: known = 1'b0; // reserved codes
    endcase
  end
endmodule

// ==== verilog/scd_dispatcher.sv ====
// supervisory call dispatcher: guard check, service launch, return code
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
module scd_dispatcher (
  input wire logic pclk,
  input wire logic presetn,
  scd_if.dispatcher link,
  output logic svc_start,
  output logic [7:0] svc_code,
  output logic [7:0] svc_block,
  output logic [7:0] svc_offset,
  output logic [7:0] svc_page,
  input wire logic svc_done,
  input wire logic [7:0] svc_result,
  input wire logic rd_protected,
  input wire logic wr_protected
);
  typedef enum logic [7:0] {
    SCD_IDLE = 8'h01,
    SCD_READ = 8'h02,
    SCD_CHECK = 8'h04,
    SCD_LAUNCH = 8'h08,
    SCD_RUN = 8'h10,
    SCD_WRBACK = 8'h20,
    SCD_FINISH = 8'h40,
    SCD_HALT = 8'h80
  } scd_state_t;

  scd_state_t state_reg;
  logic boot_pending_reg;
  logic [7:0] acc_reg;
  logic [7:0] sp_reg;
  logic [7:0] saved_flags_reg;
  logic [7:0] rd_page_reg;
  logic [7:0] wr_page_reg;
  logic [7:0] param_reg [4];
  logic [1:0] index_reg;
  logic [7:0] rc_reg;
  logic busy_reg;
  logic done_reg;
  logic halted_reg;
  logic flags_wr_reg;
  logic [7:0] flags_out_reg;
  logic mem_req_reg;
  logic mem_we_reg;
  logic [7:0] mem_addr_reg;
  logic [7:0] mem_wdata_reg;
  logic start_reg;
  logic [7:0] page_reg;
  logic [7:0] code_sel;
  logic known;
  logic check_guards;
  scd_pkg::scd_access_t access;
  logic call_seen;
  logic guards_ok;
  logic refused;

  // idle decodes the live accumulator: the copy lags the call edge by one cycle
  assign code_sel = (state_reg == SCD_IDLE && !boot_pending_reg) ? link.acc : acc_reg;

  scd_decode u_decode (
    .code(code_sel),
    .known(known),
    .check_guards(check_guards),
    .access(access)
  );

  // the call opcode, or the pending entry after reset
  assign call_seen = boot_pending_reg
                   | (link.op_valid & (link.opcode == scd_pkg::OP_SUPERVISORY_CALL));
  // guards compared as read; clock and delay bytes are never fetched
  assign guards_ok = (param_reg[0] == scd_pkg::FIRST_GUARD_VALUE)
                   & (param_reg[1] == sp_reg + scd_pkg::SECOND_GUARD_OFFSET);
  // protection levels are inputs only, nothing here can change them
  assign refused = ((access == scd_pkg::SCD_ACC_READ) & rd_protected)
                 | ((access == scd_pkg::SCD_ACC_WRITE) & wr_protected);

  // main sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= SCD_IDLE;
    end else begin
      unique case (state_reg)
        SCD_IDLE: begin
          if (call_seen) begin
            if (!known) state_reg <= SCD_HALT;
            else if (!check_guards) state_reg <= SCD_LAUNCH;
            else state_reg <= SCD_READ;
          end
        end
        SCD_READ: if (link.mem_ack && index_reg == scd_pkg::PARAM_WORDS_READ) state_reg <= SCD_CHECK;
        SCD_CHECK: begin
          if (!guards_ok) state_reg <= SCD_HALT;
          else if (refused) state_reg <= SCD_WRBACK;
          else state_reg <= SCD_LAUNCH;
        end
        SCD_LAUNCH: state_reg <= SCD_RUN;
        SCD_RUN: if (svc_done) state_reg <= SCD_WRBACK;
        SCD_WRBACK: if (link.mem_ack) state_reg <= SCD_FINISH;
        SCD_FINISH: state_reg <= SCD_IDLE;
        SCD_HALT: state_reg <= SCD_HALT; // only reset leaves a halt
      endcase
    end
  end

  // accumulator copy; zero out of reset means warm boot first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_pending_reg <= 1'b1;
      acc_reg <= scd_pkg::ACC_RESET;
    end else begin
      if (state_reg == SCD_IDLE) boot_pending_reg <= 1'b0;
      if (state_reg == SCD_IDLE && !boot_pending_reg) acc_reg <= link.acc;
    end
  end

  // core context captured at the call
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_reg <= 8'h00;
      saved_flags_reg <= scd_pkg::FLAGS_RESET;
      rd_page_reg <= 8'h00;
      wr_page_reg <= 8'h00;
    end else if (state_reg == SCD_IDLE && call_seen) begin
      sp_reg <= link.sp;
      saved_flags_reg <= link.flags;
      rd_page_reg <= link.rd_page;
      wr_page_reg <= link.wr_page;
    end
  end

  // flags: page mode cleared on entry, old value back on finish
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_wr_reg <= 1'b0;
      flags_out_reg <= scd_pkg::FLAGS_RESET;
    end else begin
      flags_wr_reg <= 1'b0;
      if (state_reg == SCD_IDLE && call_seen) begin
        flags_wr_reg <= 1'b1;
        flags_out_reg <= link.flags & ~scd_pkg::PAGE_MODE_FIELD_MASK;
      end else if (state_reg == SCD_FINISH) begin
        flags_wr_reg <= 1'b1;
        flags_out_reg <= saved_flags_reg;
      end
    end
  end

  // parameter block access, request held until acknowledged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= 8'h00;
      mem_wdata_reg <= 8'h00;
      index_reg <= 2'h0;
    end else if (mem_req_reg) begin
      if (link.mem_ack) begin
        mem_req_reg <= 1'b0;
        index_reg <= index_reg + 2'h1;
        if (state_reg == SCD_READ && index_reg != scd_pkg::PARAM_WORDS_READ) begin
          mem_req_reg <= 1'b1;
          mem_addr_reg <= mem_addr_reg + 8'h01;
        end
      end
    end else if (state_reg == SCD_IDLE && call_seen && known && check_guards) begin
      mem_req_reg <= 1'b1;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= scd_pkg::ADDR_FIRST_GUARD;
      index_reg <= 2'h0;
    end else if ((state_reg == SCD_CHECK && guards_ok && refused)
                 || (state_reg == SCD_RUN && svc_done)) begin
      mem_req_reg <= 1'b1;
      mem_we_reg <= 1'b1;
      mem_addr_reg <= scd_pkg::ADDR_FIRST_GUARD;
      mem_wdata_reg <= (state_reg == SCD_RUN) ? svc_result : scd_pkg::RC_PROTECTED;
    end
  end

  // bytes fetched from the parameter block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) param_reg[i] <= 8'h00;
    end else if (state_reg == SCD_READ && link.mem_ack) begin
      param_reg[index_reg] <= link.mem_rdata;
    end
  end

  // service launch with the block number, offset and buffer page
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_reg <= 1'b0;
      page_reg <= 8'h00;
      rc_reg <= scd_pkg::RC_SUCCESS;
    end else begin
      start_reg <= (state_reg == SCD_LAUNCH);
      // a read fills the buffer through the write page, a write drains the read page
      if (state_reg == SCD_LAUNCH)
        page_reg <= (access == scd_pkg::SCD_ACC_READ) ? wr_page_reg : rd_page_reg;
      if (state_reg == SCD_RUN && svc_done) rc_reg <= svc_result;
    end
  end

  // core hold-off, resume pulse and halt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      halted_reg <= 1'b0;
    end else begin
      done_reg <= (state_reg == SCD_FINISH);
      if (state_reg == SCD_IDLE && call_seen) busy_reg <= 1'b1;
      else if (state_reg == SCD_FINISH) busy_reg <= 1'b0;
      if (state_reg == SCD_HALT) halted_reg <= 1'b1;
    end
  end

  assign svc_start = start_reg;
  assign svc_code = acc_reg;
  assign svc_block = param_reg[2];
  assign svc_offset = param_reg[3];
  assign svc_page = page_reg;
  assign link.busy = busy_reg;
  assign link.done = done_reg;
  assign link.halted = halted_reg;
  assign link.flags_wr = flags_wr_reg;
  assign link.flags_out = flags_out_reg;
  assign link.mem_req = mem_req_reg;
  assign link.mem_we = mem_we_reg;
  assign link.mem_addr = mem_addr_reg;
  assign link.mem_wdata = mem_wdata_reg;
endmodule

// ==== verilog/scd_caller.sv ====
// caller end: apb-controlled core model issuing the supervisory call
module scd_caller (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  scd_if.caller link
);
  logic [7:0] acc_reg;
  logic [7:0] opcode_reg;
  logic auto_guard_reg;
  logic [7:0] block_reg;
  logic [7:0] offset_reg;
  logic [7:0] sp_reg;
  logic [7:0] rd_page_reg;
  logic [7:0] wr_page_reg;
  logic [7:0] flags_reg;
  logic [7:0] guard1_reg;
  logic [7:0] guard2_reg;
  logic [7:0] pblock_reg [8];
  logic op_valid_reg;
  logic mem_ack_reg;
  logic [7:0] mem_rdata_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic wr_go;
  logic auto_now;
  logic access_ok;
  logic [31:0] read_mux;

  assign access_ok = psel & penable & pready_reg;
  assign wr_go = access_ok & pwrite & (paddr == scd_pkg::REG_CTRL) & pwdata[scd_pkg::CTRL_GO_BIT]
               & ~link.busy & ~link.halted;
  // the go write carries its own guard mode, the stored bit would lag
  assign auto_now = pwdata[scd_pkg::CTRL_AUTO_GUARD_BIT];

  // read view of the caller registers
  always_comb begin
    read_mux = 32'h0000_0000;
    unique case (paddr)
      scd_pkg::REG_CTRL: read_mux = {22'h00_0000, auto_guard_reg, 1'b0, acc_reg};
      scd_pkg::REG_PARAM: read_mux = {sp_reg, wr_page_reg, offset_reg, block_reg};
      scd_pkg::REG_STATUS: read_mux = {8'h00, pblock_reg[0], 8'h00, 6'h00, link.halted, link.busy};
      scd_pkg::REG_FLAGS: read_mux = {8'h00, rd_page_reg, opcode_reg, flags_reg};
      scd_pkg::REG_GUARDS: read_mux = {16'h0000, guard2_reg, guard1_reg};
      default: read_mux = 32'h0000_0000;
    endcase
  end

  // apb slave: one wait-free access phase, unmapped offsets error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= psel & ~penable;
      prdata_reg <= read_mux;
      pslverr_reg <= psel & ~penable & (paddr > scd_pkg::REG_GUARDS || paddr[1:0] != 2'h0);
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= scd_pkg::ACC_RESET;
      opcode_reg <= scd_pkg::OP_SUPERVISORY_CALL;
      auto_guard_reg <= 1'b1;
      {sp_reg, wr_page_reg, offset_reg, block_reg} <= 32'h0000_0000;
      rd_page_reg <= 8'h00;
      guard1_reg <= 8'h00;
      guard2_reg <= 8'h00;
    end else if (access_ok && pwrite && !pslverr_reg) begin
      unique case (paddr)
        scd_pkg::REG_CTRL: begin
          acc_reg <= pwdata[7:0];
          auto_guard_reg <= pwdata[scd_pkg::CTRL_AUTO_GUARD_BIT];
        end
        scd_pkg::REG_PARAM: {sp_reg, wr_page_reg, offset_reg, block_reg} <= pwdata;
        scd_pkg::REG_FLAGS: {rd_page_reg, opcode_reg} <= pwdata[23:8];
        scd_pkg::REG_GUARDS: {guard2_reg, guard1_reg} <= pwdata[15:0];
        default: acc_reg <= acc_reg;
      endcase
    end
  end

  // core flags: software load, dispatcher overrides during a call
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= scd_pkg::FLAGS_RESET;
    end else if (link.flags_wr) begin
      flags_reg <= link.flags_out;
    end else if (access_ok && pwrite && paddr == scd_pkg::REG_FLAGS && !link.busy) begin
      flags_reg <= pwdata[7:0];
    end
  end

  // parameter block filled on the same edge as the opcode issues, guards included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) pblock_reg[i] <= 8'h00;
      op_valid_reg <= 1'b0;
    end else begin
      op_valid_reg <= wr_go;
      if (wr_go) begin // guards set by a go write, first guard also by the result write
        pblock_reg[0] <= auto_now ? scd_pkg::FIRST_GUARD_VALUE : guard1_reg;
        pblock_reg[1] <= auto_now ? sp_reg + scd_pkg::SECOND_GUARD_OFFSET
                                        : guard2_reg;
        pblock_reg[2] <= block_reg;
        pblock_reg[3] <= offset_reg;
      end else if (link.mem_req && link.mem_we && !mem_ack_reg) begin
        pblock_reg[link.mem_addr[2:0]] <= link.mem_wdata;
      end
    end
  end

  // page-0 port for the dispatcher, acknowledge one cycle after request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack_reg <= 1'b0;
      mem_rdata_reg <= 8'h00;
    end else begin
      mem_ack_reg <= link.mem_req & ~mem_ack_reg;
      mem_rdata_reg <= (link.mem_addr[7:3] == scd_pkg::ADDR_FIRST_GUARD[7:3])
                     ? pblock_reg[link.mem_addr[2:0]] : 8'h00;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign link.op_valid = op_valid_reg;
  assign link.opcode = opcode_reg;
  assign link.acc = acc_reg;
  assign link.sp = sp_reg;
  assign link.flags = flags_reg;
  assign link.rd_page = rd_page_reg;
  assign link.wr_page = wr_page_reg;
  assign link.mem_ack = mem_ack_reg;
  assign link.mem_rdata = mem_rdata_reg;
endmodule

// ==== test/scd_properties.sv ====
// link checks for the supervisory call dispatcher
module scd_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic op_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] acc,
  input wire logic [7:0] flags,
  input wire logic busy,
  input wire logic done,
  input wire logic halted,
  input wire logic flags_wr,
  input wire logic [7:0] flags_out,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic call;
  logic defined;
  logic warm_reg;
  logic [7:0] saved_reg;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // a call counts only while the dispatcher idles
  assign call = op_valid && opcode == 8'h00 && !busy && !halted;
  assign defined = acc inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0F};

  // flags and kind of the running call; reset itself enters a warm boot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      saved_reg <= 8'h00;
      warm_reg <= 1'b1;
    end else if (call) begin
      saved_reg <= flags;
      warm_reg <= acc == 8'h00;
    end
  end

  sequence s_next_fetch;
    mem_req && !mem_we && mem_addr == $past(mem_addr) + 8'h01;
  endsequence
  sequence s_finish;
    flags_out == saved_reg ##[0:1] done;
  endsequence

  a_call_enters: assert property (
    call |=> busy && flags_wr && flags_out == ($past(flags) & 8'h3F))
    else $error("call entry wrong");
  a_other_ignored: assert property (
    op_valid && opcode != 8'h00 && !busy && !halted |=> !busy)
    else $error("other opcode entered");
  a_done_frees: assert property (done |-> !busy && $past(busy))
    else $error("done without busy end");
  a_flags_restore: assert property (flags_wr && !$rose(busy) |-> s_finish)
    else $error("flags not restored");
  a_warm_no_read: assert property (busy && warm_reg |-> !(mem_req && !mem_we))
    else $error("warm boot read guards");
  a_first_fetch: assert property (
    call && acc != 8'h00 && defined |=> mem_req && !mem_we && mem_addr == 8'hF8)
    else $error("first fetch wrong");
  a_fetch_order: assert property (
    mem_req && mem_ack && !mem_we && mem_addr inside {8'hF8, 8'hF9, 8'hFA} |=> s_next_fetch)
    else $error("fetch order wrong");
  a_param_place: assert property (mem_req |-> mem_addr inside {[8'hF8:8'hFB]})
    else $error("access outside block");
  a_result_place: assert property (mem_req && mem_we |-> mem_addr == 8'hF8)
    else $error("result not at first guard");
  a_req_held: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
    else $error("request not held");
  a_undef_halts: assert property (
    call && !defined |=> !mem_req throughout (##[0:4] halted))
    else $error("undefined code not halted");
  a_halt_sticky: assert property (halted |=> halted && !done && !mem_req)
    else $error("halt left");
endmodule

// ==== test/testbench.sv ====
// self-checking bench: caller and dispatcher joined over the link
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic svc_start;
  logic [7:0] svc_code;
  logic [7:0] svc_block;
  logic [7:0] svc_offset;
  logic [7:0] svc_page;
  logic svc_done = 1'b0;
  logic [7:0] svc_result = 8'h00;
  logic rd_protected = 1'b0;
  logic wr_protected = 1'b0;
  logic [31:0] rdata;
  logic rerr;
  logic [7:0] got_code;
  logic [7:0] got_blk;
  logic [7:0] got_off;
  logic [7:0] got_page;
  int n_start = 0;
  int error_cnt = 0;
  int samples_checked = 0;

  always #5 pclk = ~pclk;

  scd_if i_scd_if (.pclk(pclk), .presetn(presetn));
  scd_caller i_scd_caller (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(i_scd_if));
  scd_dispatcher i_scd_dispatcher (.pclk(pclk), .presetn(presetn), .link(i_scd_if),
    .svc_start(svc_start), .svc_code(svc_code), .svc_block(svc_block),
    .svc_offset(svc_offset), .svc_page(svc_page), .svc_done(svc_done),
    .svc_result(svc_result), .rd_protected(rd_protected), .wr_protected(wr_protected));
  scd_properties i_scd_properties (.pclk(pclk), .presetn(presetn),
    .op_valid(i_scd_if.op_valid), .opcode(i_scd_if.opcode), .acc(i_scd_if.acc),
    .flags(i_scd_if.flags), .busy(i_scd_if.busy), .done(i_scd_if.done),
    .halted(i_scd_if.halted), .flags_wr(i_scd_if.flags_wr), .flags_out(i_scd_if.flags_out),
    .mem_req(i_scd_if.mem_req), .mem_we(i_scd_if.mem_we), .mem_addr(i_scd_if.mem_addr),
    .mem_wdata(i_scd_if.mem_wdata), .mem_ack(i_scd_if.mem_ack));

  // service stand-in: records the launch and finishes on the next cycle
  always @(posedge pclk) begin
    svc_done <= 1'b0;
    if (svc_start === 1'b1) begin
      got_code <= svc_code;
      got_blk <= svc_block;
      got_off <= svc_offset;
      got_page <= svc_page;
      n_start <= n_start + 1;
      svc_done <= 1'b1;
    end
  end

  task finish_test;
    $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task chk(input logic [7:0] g, input logic [7:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  // one apb transfer; an idle cycle follows so strobes never toggle twice
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      finish_test();
    end
    @(posedge pclk);
  endtask

  // busy shows two cycles after a go write, so polling starts late
  task wait_idle;
    int n;
    n = 0;
    repeat (3) @(posedge pclk);
    do begin
      apb(1'b0, 8'h08, 32'h0);
      n++;
    end while (rdata[0] === 1'b1 && rdata[1] !== 1'b1 && n < 40);
    if (rdata[0] === 1'b1 && rdata[1] !== 1'b1) begin
      error_cnt++;
      finish_test();
    end
  endtask

  task reset_dut;
    int n0;
    n0 = n_start;
    presetn <= 1'b0;
    svc_result <= 8'h02;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wait_idle();
    chk(8'(n_start - n0), 8'h01, "boot launches");
    chk(got_code, 8'h00, "boot code");
    chk(rdata[23:16], 8'h02, "boot result");
  endtask

  // block 12h, offset 34h, write page 56h, sp 40h, read page 78h, flags C5h
  task setup(input logic [7:0] opc);
    apb(1'b1, 8'h04, 32'h40563412);
    apb(1'b1, 8'h0C, {8'h00, 8'h78, opc, 8'hC5});
  endtask

  task run(input logic [31:0] ctrl, input logic [7:0] res, input logic [7:0] rc,
           input logic [7:0] starts, input logic halt);
    int n0;
    n0 = n_start;
    svc_result <= res;
    apb(1'b1, 8'h00, ctrl);
    wait_idle();
    chk({7'h0, rdata[1]}, {7'h0, halt}, "halted");
    if (!halt) chk(rdata[23:16], rc, "return code");
    chk(8'(n_start - n0), starts, "launches");
    if (starts != 8'h00) begin
      chk(got_code, ctrl[7:0], "service code");
      chk(got_blk, 8'h12, "block number");
      chk(got_off, 8'h34, "buffer offset");
    end
    if (starts != 8'h00 && ctrl[7:0] == 8'h01) chk(got_page, 8'h56, "read page");
    if (starts != 8'h00 && ctrl[7:0] == 8'h02) chk(got_page, 8'h78, "write page");
    if (!halt) begin
      apb(1'b0, 8'h0C, 32'h0);
      chk(rdata[7:0], 8'hC5, "flags after call");
    end
  endtask

  task t_codes;
    logic [7:0] c [10];
    c = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0F, 8'h00};
    setup(8'h00);
    foreach (c[i]) run({22'h0, 2'b11, c[i]}, c[i] ^ 8'h50, c[i] ^ 8'h50, 8'h01, 1'b0);
    $display("test codes done");
  endtask

  task t_protect;
    logic [7:0] c [3];
    c = '{8'h02, 8'h03, 8'h0A};
    rd_protected <= 1'b1;
    run(32'h00000301, 8'h55, 8'h01, 8'h00, 1'b0);
    rd_protected <= 1'b0;
    wr_protected <= 1'b1;
    run(32'h00000301, 8'h55, 8'h55, 8'h01, 1'b0);
    foreach (c[i]) run({22'h0, 2'b11, c[i]}, 8'h55, 8'h01, 8'h00, 1'b0);
    wr_protected <= 1'b0;
    $display("test protection done");
  endtask

  // a non-call opcode must leave the dispatcher idle; unmapped offset errs
  task t_opcode;
    int n0;
    setup(8'h05);
    n0 = n_start;
    apb(1'b1, 8'h00, 32'h00000301);
    wait_idle();
    chk({6'h0, rdata[1:0]}, 8'h00, "status after opcode");
    chk(8'(n_start - n0), 8'h00, "launches after opcode");
    apb(1'b1, 8'h14, 32'h0);
    chk({7'h0, rerr}, 8'h01, "slave error");
    setup(8'h00);
    $display("test opcode done");
  endtask

  // manual guards: good, bad on warm boot, bad first, bad second, undefined codes
  task t_guards;
    logic [15:0] g [6];
    logic [7:0] a [6];
    logic h [6];
    g = '{16'h433A, 16'h0000, 16'h433B, 16'h423A, 16'h433A, 16'h433A};
    a = '{8'h01, 8'h00, 8'h01, 8'h01, 8'h04, 8'h10};
    h = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    foreach (g[i]) begin
      apb(1'b1, 8'h10, {16'h0, g[i]});
      run({22'h0, 2'b01, a[i]}, 8'h21, 8'h21, {7'h0, !h[i]}, h[i]);
      if (h[i]) begin
        reset_dut();
        setup(8'h00);
      end
    end
    $display("test guards done");
  endtask

  initial begin
    reset_dut();
    $display("test boot done");
    t_codes();
    t_protect();
    t_opcode();
    t_guards();
    finish_test();
  end
endmodule
